// *** design/bsia_regs.vh ***
// Operation
// - Grant only when no acknowledge; pulse later
// - Acknowledge removes select; blocks new cycles
// - Transfer requests beat interrupt and cpu
// - Four interrupt request/select pairs
// - Power fail, restart, tick raise level 4
// - Attention key or signal raise level 1
// - Internal interrupts beat module interrupts on the same level
// - Notify cpu unless inhibited or masked
// - Instruction end: select module interrupt line, then pulse
// - Selection masks all four levels
// - Deliver serviced line number to cpu
// - Vector base per level 0000..0018
// - Levels five, six private to cpu
// - Response about 5.9 us
// - Cpu requests lowest priority
`ifndef BSIA_REGS_VH
`define BSIA_REGS_VH
// Delay from select to precedence pulse, and pulse width, in ns
`define BSIA_PCD_DELAY_NS 100
`define BSIA_PCD_WIDTH_NS 60
`define BSIA_CLK_NS 20
// Vector base spacing in bytes per level
`define BSIA_VEC_STRIDE 16'h0008
`define BSIA_VEC_BASE 16'h0000
`define BSIA_LEVELS 4
`define BSIA_MASK_RESET 4'h0
`endif

// *** design/bsia_arbiter.v ***
`timescale 1ns/1ps
`include "bsia_regs.vh"
// Central select-cycle arbiter. Bus pins are active low and pass two flops.
module bsia_arbiter (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Request lines from the backplane (active low)
    input wire dev_transfer_request_n,
    input wire [3:0] irq_request_line_n,
    input wire cpu_request_line_n,
    input wire select_acknowledge_n,
    // Internal interrupt sources (active high except external_attention_n, async)
    input wire power_fail,
    input wire power_restart,
    input wire line_tick,
    input wire panel_attention_key,
    input wire external_attention_n,
    // Processor side (same clock)
    input wire global_irq_inhibit,
    input wire [3:0] irq_mask_set,
    input wire [3:0] irq_mask_clear,
    input wire instr_end,
    // Select outputs (active low)
    output reg dev_transfer_grant_n,
    output reg [3:0] irq_select_set_n,
    output reg cpu_select_n,
    output reg precedence_pulse_n,
    // Processor notification
    output wire irq_pending,
    output reg internal_irq,
    output reg [2:0] serviced_line,
    output reg [15:0] vector_base,
    output reg [3:0] irq_mask_q
);
    // Cycle counts derived from ns figures; least times round up
    // Rounding up means a faster clock never shortens the settle time
    // that masters on the far end of the chain rely on
    localparam [7:0] DLY_CYC = (`BSIA_PCD_DELAY_NS + `BSIA_CLK_NS - 1) / `BSIA_CLK_NS;
    localparam [7:0] WID_CYC = (`BSIA_PCD_WIDTH_NS + `BSIA_CLK_NS - 1) / `BSIA_CLK_NS;
    // One-hot states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_DLY = 4'h2;
    localparam [3:0] ST_PULSE = 4'h4;
    localparam [3:0] ST_WACK = 4'h8;

    // Two-flop synchronisers for every asynchronous input
    // Reset value is all ones, the idle level of every stage, so the
    // edge detectors below see no false event as reset is released
    reg [11:0] s1_q, s2_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 12'hFFF;
            s2_q <= 12'hFFF;
        end else begin
            s1_q <= {dev_transfer_request_n, irq_request_line_n, cpu_request_line_n,
                     select_acknowledge_n, ~power_fail, ~power_restart, ~line_tick,
                     ~panel_attention_key, external_attention_n};
            s2_q <= s1_q;
        end
    end
    // Decoded active-high views of the second stage
    wire dev_req = ~s2_q[11];
    wire [3:0] irq_req = ~s2_q[10:7];
    wire cpu_req = ~s2_q[6];
    wire ack = ~s2_q[5];
    wire [2:0] pwr_ev = ~s2_q[4:2];
    wire panel_attention_key_ev = ~s2_q[1] | ~s2_q[0];

    // Edge memory so internal events latch once per occurrence
    reg [2:0] pwr_prev_q;
    reg panel_attention_key_prev_q;
    reg int4_q, int1_q;

    // Effective line requests include internal sources
    wire [3:0] line_req = irq_req | {int4_q, 2'b00, int1_q};
    wire [3:0] line_ok = line_req & ~irq_mask_q;
    assign irq_pending = ~global_irq_inhibit & (|line_ok);

    // Highest numbered unmasked level wins among lines
    // Only the four shared levels exist here; the private trap levels
    // five and six stay inside each processor and never reach this block
    function [1:0] pick;
        input [3:0] v;
        begin
            if (v[3]) pick = 2'd3;
            else if (v[2]) pick = 2'd2;
            else if (v[1]) pick = 2'd1;
            else pick = 2'd0;
        end
    endfunction

    reg [3:0] st_q;
    reg [7:0] cnt_q;
    reg [1:0] kind_q; // 0 dev, 1 line, 2 cpu
    reg [1:0] lvl_q;
    reg use_int_q; // Current cycle serves an internal source
    reg take_q; // Instruction end seen with a line pending
    wire [1:0] lvl_pick = pick(line_ok);
    wire int_pick = (lvl_pick == 2'd3) ? int4_q : ((lvl_pick == 2'd0) ? int1_q : 1'b0);
    // Clear strobes for the internal flags fire only in the cycle in which
    // the sequencer really services that source, so an inhibited or
    // masked internal event is never lost
    wire svc_int = (st_q == ST_IDLE) && !ack && !dev_req && take_q && irq_pending && int_pick;
    wire clr4 = svc_int && (lvl_pick == 2'd3);
    wire clr1 = svc_int && (lvl_pick == 2'd0);

    // Internal interrupt pending flags; set wins over clear
    // A new event in the very cycle of service stays pending, so the
    // processor sees it again rather than losing it
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwr_prev_q <= 3'h0;
            panel_attention_key_prev_q <= 1'b0;
            int4_q <= 1'b0;
            int1_q <= 1'b0;
        end else begin
            pwr_prev_q <= pwr_ev;
            panel_attention_key_prev_q <= panel_attention_key_ev;
            if (|(pwr_ev & ~pwr_prev_q))
                int4_q <= 1'b1;
            else if (clr4)
                int4_q <= 1'b0;
            if (panel_attention_key_ev & ~panel_attention_key_prev_q)
                int1_q <= 1'b1;
            else if (clr1)
                int1_q <= 1'b0;
        end
    end

    // Select-cycle sequencer
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= 8'h00;
            kind_q <= 2'd0;
            lvl_q <= 2'd0;
            use_int_q <= 1'b0;
            take_q <= 1'b0;
            dev_transfer_grant_n <= 1'b1;
            irq_select_set_n <= 4'hF;
            cpu_select_n <= 1'b1;
            precedence_pulse_n <= 1'b1;
            irq_mask_q <= `BSIA_MASK_RESET;
            internal_irq <= 1'b0;
            serviced_line <= 3'd0;
            vector_base <= `BSIA_VEC_BASE;
        end else begin
            irq_mask_q <= irq_mask_q & ~irq_mask_clear | irq_mask_set;
            if (instr_end && irq_pending)
                take_q <= 1'b1;
            case (st_q)
                ST_IDLE: begin
                    // No new cycle while a selected master waits
                    if (!ack) begin
                        if (dev_req) begin
                            dev_transfer_grant_n <= 1'b0;
                            kind_q <= 2'd0;
                            st_q <= ST_DLY;
                            cnt_q <= DLY_CYC;
                        end else if (take_q && irq_pending) begin
                            take_q <= 1'b0;
                            lvl_q <= lvl_pick;
                            kind_q <= 2'd1;
                            use_int_q <= int_pick;
                            irq_mask_q <= 4'hF;
                            serviced_line <= {1'b0, lvl_pick} + 3'd1;
                            vector_base <= `BSIA_VEC_BASE + {12'h000, lvl_pick, 2'b00} *
                                           `BSIA_VEC_STRIDE / 16'h0004;
                            if (int_pick) begin
                                // Internal source needs no bus selection
                                // Skipping the select cycle keeps the
                                // response short for power events
                                internal_irq <= 1'b1;
                            end else begin
                                irq_select_set_n[lvl_pick] <= 1'b0;
                                st_q <= ST_DLY;
                                cnt_q <= DLY_CYC;
                            end
                        end else if (cpu_req) begin
                            cpu_select_n <= 1'b0;
                            kind_q <= 2'd2;
                            st_q <= ST_DLY;
                            cnt_q <= DLY_CYC;
                        end
                    end
                    if (internal_irq)
                        internal_irq <= 1'b0;
                end
                ST_DLY: begin
                    // Settle time between select and precedence pulse
                    if (cnt_q <= 8'h01) begin
                        precedence_pulse_n <= 1'b0;
                        cnt_q <= WID_CYC;
                        st_q <= ST_PULSE;
                    end else
                        cnt_q <= cnt_q - 8'h01;
                end
                ST_PULSE: begin
                    // Pulse width, then await the acknowledge
                    if (cnt_q <= 8'h01) begin
                        precedence_pulse_n <= 1'b1;
                        st_q <= ST_WACK;
                    end else
                        cnt_q <= cnt_q - 8'h01;
                end
                ST_WACK: begin
                    // Acknowledge ends select; a missing one leaves it up
                    if (ack) begin
                        dev_transfer_grant_n <= 1'b1;
                        irq_select_set_n <= 4'hF;
                        cpu_select_n <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // bsia_arbiter

// *** dv/bsia_arbiter_asserts.sv ***
`timescale 1ns/1ps
// Watches select, pulse and mask outputs; sel_any folds every select line into one flag
module bsia_arbiter_asserts (
    input wire clk, input wire resetn, input wire select_acknowledge_n,
    input wire global_irq_inhibit, input wire dev_transfer_grant_n,
    input wire [3:0] irq_select_set_n, input wire cpu_select_n,
    input wire precedence_pulse_n, input wire irq_pending,
    input wire [2:0] serviced_line, input wire [15:0] vector_base,
    input wire [3:0] irq_mask_q
);
    wire irq_sel = irq_select_set_n != 4'hF;
    wire sel_any = irq_sel || !dev_transfer_grant_n || !cpu_select_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_pulse_after_sel: assert property ($fell(precedence_pulse_n) |-> $past(sel_any, 5))
        else $error("pulse without select");
    a_pulse_width: assert property ($fell(precedence_pulse_n) |->
        !precedence_pulse_n [*3] ##1 precedence_pulse_n) else $error("pulse width");
    a_ack_drops_sel: assert property (sel_any && $fell(select_acknowledge_n) |->
        ##[1:4] !sel_any) else $error("select kept after ack");
    a_ack_bars_sel: assert property (!select_acknowledge_n [*5] |-> !sel_any)
        else $error("select during ack");
    a_one_select: assert property ($onehot0({!dev_transfer_grant_n, ~irq_select_set_n,
        !cpu_select_n})) else $error("two selects");
    a_mask_on_sel: assert property ($rose(irq_sel) |-> ##[0:4] irq_mask_q == 4'hF)
        else $error("levels not masked");
    a_pending_gate: assert property (irq_pending |-> !global_irq_inhibit)
        else $error("pending while inhibited");
    a_vector_base: assert property (serviced_line != 3'h0 |->
        vector_base == {10'h000, serviced_line - 3'h1, 3'h0}) else $error("vector base");
    a_reset_idle: assert property (disable iff (1'h0) !resetn |->
        !sel_any && precedence_pulse_n) else $error("not idle in reset");
    c_dev: cover property ($fell(dev_transfer_grant_n));
    c_irq: cover property ($rose(irq_sel));
    c_pulse: cover property ($fell(precedence_pulse_n));
endmodule // bsia_arbiter_asserts

// *** dv/bsia_master_model.sv ***
`timescale 1ns/1ps
// One master module; lvl 0 asks for a transfer, 1..4 for that interrupt level
module bsia_master_model #(parameter HOLD = 8) (
    input wire clk, input wire go, input wire [2:0] lvl,
    input wire dev_transfer_grant_n, input wire [3:0] irq_select_set_n,
    input wire precedence_pulse_n, output wire dev_transfer_request_n,
    output wire [3:0] irq_request_line_n, output reg select_acknowledge_n = 1'h1
);
    reg req = 1'h0;
    integer cnt = 0;
    wire sel = lvl == 0 ? !dev_transfer_grant_n : !irq_select_set_n[lvl - 1];
    assign dev_transfer_request_n = !(req && lvl == 0);
    assign irq_request_line_n = (req && lvl != 0) ? ~(4'h1 << (lvl - 1)) : 4'hF;
    // Ack is held HOLD+1 cycles so the waiting state is visible
    always @(posedge clk) begin
        if (go && !sel) req <= 1'h1;
        if (req && sel && !precedence_pulse_n && select_acknowledge_n) begin
            select_acknowledge_n <= 1'h0;
            cnt <= HOLD;
        end else if (!select_acknowledge_n) begin
            req <= 1'h0;
            cnt <= cnt - 1;
            if (cnt == 0) select_acknowledge_n <= 1'h1;
        end
    end
endmodule // bsia_master_model

// *** dv/test_bus_select_and_interrupt_arbiter.sv ***
`timescale 1ns/1ps
module test_bus_select_and_interrupt_arbiter;
    reg clk = 1'h0, resetn = 1'h1, cpu_n = 1'h1, inh = 1'h0, ie = 1'h0, go = 1'h0;
    reg [3:0] mset = 4'h0, mclr = 4'h0;
    reg [4:0] ev = 5'h00;
    reg [2:0] lvl = 3'h0;
    wire dreq_n, ack_n, gnt_n, csel_n, pp_n, pend, iirq;
    wire [3:0] ireq_n, isel_n, mask;
    wire [2:0] sl;
    wire [15:0] vb;
    integer miscompares = 0, checks_done = 0, cyc = 0, n, i;
    always #10 clk = ~clk;
    bsia_arbiter dut (.clk(clk), .resetn(resetn), .dev_transfer_request_n(dreq_n),
        .irq_request_line_n(ireq_n), .cpu_request_line_n(cpu_n), .select_acknowledge_n(ack_n),
        .power_fail(ev[0]), .power_restart(ev[1]), .line_tick(ev[2]),
        .panel_attention_key(ev[3]), .external_attention_n(~ev[4]),
        .global_irq_inhibit(inh), .irq_mask_set(mset), .irq_mask_clear(mclr), .instr_end(ie),
        .dev_transfer_grant_n(gnt_n), .irq_select_set_n(isel_n), .cpu_select_n(csel_n),
        .precedence_pulse_n(pp_n), .irq_pending(pend), .internal_irq(iirq),
        .serviced_line(sl), .vector_base(vb), .irq_mask_q(mask));
    bsia_master_model peer (.clk(clk), .go(go), .lvl(lvl), .dev_transfer_grant_n(gnt_n),
        .irq_select_set_n(isel_n), .precedence_pulse_n(pp_n), .dev_transfer_request_n(dreq_n),
        .irq_request_line_n(ireq_n), .select_acknowledge_n(ack_n));
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task step(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Master starts asking at level l; go is pulsed for one cycle, no wait for ack
    task serve(input [2:0] l);
        lvl = l;
        go = 1'h1;
        step(1);
        go = 1'h0;
    endtask
    // Transfer request beats a simultaneous cpu request; fixed select and pulse latency
    task t_dev;
        serve(3'h0);
        cpu_n = 1'h0;
        n = 0;
        while (gnt_n) begin step(1); n = n + 1; end
        check(n, 3);
        check(csel_n, 1'h1);
        cpu_n = 1'h1;
        n = 0;
        while (pp_n) begin step(1); n = n + 1; end
        check(n, 5);
        while (ack_n) step(1);
        step(4);
        check(gnt_n, 1'h1);
        while (!ack_n) step(1);
    endtask
    // Every line: inhibit, mask, then service and vector
    task t_lines;
        for (i = 1; i <= 4; i = i + 1) begin
            inh = 1'h1;
            serve(i[2:0]);
            step(4);
            check(pend, 1'h0);
            inh = 1'h0;
            #1 check(pend, i == 1);
            mclr = 4'hF;
            step(1);
            mclr = 4'h0;
            check(pend, 1'h1);
            ie = 1'h1;
            step(1);
            ie = 1'h0;
            while (ack_n) step(1);
            while (!ack_n) step(1);
            check(sl, i);
            check(vb, (i - 1) * 8);
            check(mask, 4'hF);
        end
    endtask
    // Internal events: three at level four, two at level one
    task t_internal;
        for (i = 0; i < 5; i = i + 1) begin
            mclr = 4'hF;
            ev = 5'h01 << i;
            step(4);
            mclr = 4'h0;
            ev = 5'h00;
            ie = 1'h1;
            step(1);
            ie = 1'h0;
            n = 0;
            while (!iirq && n < 20) begin step(1); n = n + 1; end
            check(iirq, 1'h1);
            check(sl, i < 3 ? 4 : 1);
            check(isel_n, 4'hF);
            step(4);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #2 resetn = 1'h0;
        step(4);
        check({gnt_n, isel_n, csel_n, pp_n}, 7'h7F);
        resetn = 1'h1;
        step(2);
        t_dev;
        t_lines;
        t_internal;
        tally_and_finish;
    end
endmodule // test_bus_select_and_interrupt_arbiter
bind bsia_arbiter bsia_arbiter_asserts chk (.clk(clk), .resetn(resetn),
    .select_acknowledge_n(select_acknowledge_n), .global_irq_inhibit(global_irq_inhibit),
    .dev_transfer_grant_n(dev_transfer_grant_n), .irq_select_set_n(irq_select_set_n),
    .cpu_select_n(cpu_select_n), .precedence_pulse_n(precedence_pulse_n),
    .irq_pending(irq_pending), .serviced_line(serviced_line), .vector_base(vector_base),
    .irq_mask_q(irq_mask_q));
